//--- crs_defs.svh
// Purpose: constants of the cpu register set and reset entry
// Assumes: 20-bit address space, 16-bit register words
// Notes: apb offsets are byte addresses
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_I 6
`define CRS_FLG_U 7
`define CRS_FLG_IPL_LO 12
`define CRS_FLG_IPL_HI 14
`define CRS_FLG_WMASK 16'h70FF
`define CRS_FLG_RESET 16'h0000
`define CRS_OFS_MODE0 12'h004
`define CRS_MODE0_SWRST 3
`define CRS_OFS_FLAGS 12'h100
`define CRS_OFS_PC 12'h104
`define CRS_OFS_VECTOR_TABLE_BASE 12'h108
`define CRS_OFS_SB 12'h10C
`define CRS_OFS_USP 12'h110
`define CRS_OFS_ISP 12'h114
`define CRS_OFS_STATUS 12'h118
`define CRS_RST_MIN_CYC 5'd20
`define CRS_FIXVEC_BASE 20'hFFFDC
`define CRS_FIXVEC_LAST 20'hFFFFF
`define CRS_FIXVEC_RESET 4'd8
`define CRS_FIXVEC_CNT 4'd9
`define CRS_SPVEC_BASE 20'hFFE00
`define CRS_SPVEC_CNT 8'd238
`define CRS_SFR_LAST 20'h003FF
`define CRS_RAM_BASE 20'h00400
`define CRS_SWTRAP_LIMIT 6'd32
`define CRS_IDX_SB 4'd7
`define CRS_IDX_SP 4'd8
`define CRS_IDX_USP 4'd9
`define CRS_IDX_ISP 4'd10
`define CRS_IDX_FLG 4'd11
`endif

//--- crs_pkg.sv
// Purpose: types of the cpu register set
// Assumes: crs_defs.svh holds all figures
// Notes: register index 0-6 is banked, 7-11 common
package crs_pkg;
	typedef logic [15:0] crs_word_t;
	typedef logic [19:0] crs_addr_t;
	typedef enum logic [1:0] {
		CRS_SZ_LOW = 2'h0,
		CRS_SZ_HIGH = 2'h1,
		CRS_SZ_WORD = 2'h2,
		CRS_SZ_LONG = 2'h3
	} crs_size_e;
	typedef enum logic [2:0] {
		CRS_ST_RESET = 3'b001,
		CRS_ST_VECTOR = 3'b010,
		CRS_ST_RUN = 3'b100
	} crs_state_e;
	typedef enum logic [1:0] {
		CRS_RGN_SFR = 2'h0,
		CRS_RGN_RAM = 2'h1,
		CRS_RGN_OTHER = 2'h2
	} crs_region_e;
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		crs_size_e size;
		logic [31:0] data;
	} crs_wr_s;
	typedef struct packed {
		logic valid;
		logic carry;
		logic ovf;
		crs_word_t result;
	} crs_alu_s;
	typedef struct packed {
		logic req;
		logic nmi;
		logic [2:0] prio;
	} crs_irq_s;
	typedef struct packed {
		logic accept;
		logic step;
		logic trap;
		logic [5:0] trap_num;
	} crs_ack_s;
endpackage

//--- crs_regfile.sv
// Purpose: cpu programmer-visible registers, flag word and reset entry
// Assumes: apb slave, zero wait beyond one access cycle; reset pin from outside
// Notes: all outputs registered; banked registers reached from core port only
`timescale 1ns/1ns
`include "crs_defs.svh"
module crs_regfile (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic reset_pin_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// core register access
	input wire crs_pkg::crs_wr_s wr_in,
	input wire logic [3:0] rd_idx_in,
	input wire crs_pkg::crs_size_e rd_size_in,
	output logic [31:0] rd_data_out,
	input wire crs_pkg::crs_alu_s alu_in,
	input wire logic pc_load_in,
	input wire crs_pkg::crs_addr_t pc_next_in,
	input wire logic vector_table_base_load_in,
	input wire crs_pkg::crs_addr_t vector_table_base_next_in,
	// interrupts
	input wire crs_pkg::crs_irq_s irq_in,
	input wire crs_pkg::crs_ack_s ack_in,
	input wire logic instr_done_in,
	output logic irq_grant_out,
	output logic step_req_out,
	// vectors and map
	input wire logic [3:0] fixvec_num_in,
	input wire logic [7:0] spvec_num_in,
	output crs_pkg::crs_addr_t fixvec_addr_out,
	output crs_pkg::crs_addr_t spvec_addr_out,
	input wire crs_pkg::crs_addr_t map_addr_in,
	output crs_pkg::crs_region_e map_region_out,
	// reset entry
	output logic vec_fetch_out,
	input wire logic vec_valid_in,
	input wire crs_pkg::crs_addr_t vec_data_in,
	output logic cpu_run_out,
	// state view
	output crs_pkg::crs_word_t flags_out,
	output crs_pkg::crs_addr_t pc_out,
	output crs_pkg::crs_addr_t vector_table_base_out
);
	import crs_pkg::*;

	crs_word_t bank_q [0:1][0:6];
	crs_word_t sb_q;
	crs_word_t usp_q;
	crs_word_t isp_q;
	crs_word_t flag_q;
	crs_addr_t pc_q;
	crs_addr_t vector_table_base_q;
	crs_state_e state_q;
	logic pin_meta_q;
	logic pin_sync_q;
	logic [4:0] low_cnt_q;
	logic sw_rst_q;
	logic last_sw_q;
	logic clr;
	logic bank;
	logic apb_wr;
	logic apb_setup;
	logic pin_held;
	crs_word_t flag_d;
	logic [31:0] rd_mux;

	assign bank = flag_q[`CRS_FLG_B];
	assign clr = (state_q == CRS_ST_RESET);
	assign apb_setup = psel_in & ~penable_in;
	assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
	assign pin_held = (low_cnt_q >= `CRS_RST_MIN_CYC);

	// reset pin crosses in through two flops before anything reads it
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end else begin
			pin_meta_q <= reset_pin_n_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// short glitches on the pin are ignored; only a full hold resets
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			low_cnt_q <= 5'h00;
		end else if (pin_sync_q) begin
			low_cnt_q <= 5'h00;
		end else if (!pin_held) begin
			low_cnt_q <= low_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sw_rst_q <= 1'b0;
		end else begin
			sw_rst_q <= apb_wr && paddr_in == `CRS_OFS_MODE0 &&
				pwdata_in[`CRS_MODE0_SWRST];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= CRS_ST_RESET;
			last_sw_q <= 1'b0;
		end else if (pin_held || sw_rst_q) begin
			state_q <= CRS_ST_RESET;
			last_sw_q <= sw_rst_q;
		end else begin
			unique case (state_q)
				CRS_ST_RESET: begin
					if (pin_sync_q) begin
						state_q <= CRS_ST_VECTOR;
					end
				end
				CRS_ST_VECTOR: begin
					if (vec_valid_in) begin
						state_q <= CRS_ST_RUN;
					end
				end
				CRS_ST_RUN: begin
					state_q <= CRS_ST_RUN;
				end
				default: begin
					state_q <= CRS_ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			vec_fetch_out <= 1'b0;
			cpu_run_out <= 1'b0;
		end else begin
			vec_fetch_out <= (state_q == CRS_ST_VECTOR) && !vec_valid_in;
			cpu_run_out <= (state_q == CRS_ST_RUN) ||
				((state_q == CRS_ST_VECTOR) && vec_valid_in);
		end
	end

	// banked registers; long writes pair r2:r0, r3:r1, a1:a0
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int b = 0; b < 2; b++) begin
				for (int r = 0; r < 7; r++) begin
					bank_q[b][r] <= 16'h0000;
				end
			end
		end else if (clr) begin
			for (int b = 0; b < 2; b++) begin
				for (int r = 0; r < 7; r++) begin
					bank_q[b][r] <= 16'h0000;
				end
			end
		end else if (wr_in.en && wr_in.idx < `CRS_IDX_SB) begin
			unique case (wr_in.size)
				CRS_SZ_LOW: begin
					if (wr_in.idx < 4'd2) begin
						bank_q[bank][wr_in.idx[2:0]][7:0] <= wr_in.data[7:0];
					end
				end
				CRS_SZ_HIGH: begin
					if (wr_in.idx < 4'd2) begin
						bank_q[bank][wr_in.idx[2:0]][15:8] <= wr_in.data[7:0];
					end
				end
				CRS_SZ_WORD: begin
					bank_q[bank][wr_in.idx[2:0]] <= wr_in.data[15:0];
				end
				CRS_SZ_LONG: begin
					if (wr_in.idx < 4'd2) begin
						bank_q[bank][wr_in.idx[2:0]] <= wr_in.data[15:0];
						bank_q[bank][wr_in.idx[2:0] + 3'd2] <= wr_in.data[31:16];
					end else if (wr_in.idx == 4'd4) begin
						bank_q[bank][4] <= wr_in.data[15:0];
						bank_q[bank][5] <= wr_in.data[31:16];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sb_q <= 16'h0000;
		end else if (clr) begin
			sb_q <= 16'h0000;
		end else if (wr_in.en && wr_in.idx == `CRS_IDX_SB) begin
			sb_q <= wr_in.data[15:0];
		end else if (apb_wr && paddr_in == `CRS_OFS_SB) begin
			sb_q <= pwdata_in[15:0];
		end
	end

	// the selected stack pointer follows the flag word as it stands now
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			usp_q <= 16'h0000;
			isp_q <= 16'h0000;
		end else if (clr) begin
			usp_q <= 16'h0000;
			isp_q <= 16'h0000;
		end else if (wr_in.en && wr_in.idx == `CRS_IDX_SP) begin
			if (flag_q[`CRS_FLG_U]) begin
				usp_q <= wr_in.data[15:0];
			end else begin
				isp_q <= wr_in.data[15:0];
			end
		end else if (wr_in.en && wr_in.idx == `CRS_IDX_USP) begin
			usp_q <= wr_in.data[15:0];
		end else if (wr_in.en && wr_in.idx == `CRS_IDX_ISP) begin
			isp_q <= wr_in.data[15:0];
		end else if (apb_wr && paddr_in == `CRS_OFS_USP) begin
			usp_q <= pwdata_in[15:0];
		end else if (apb_wr && paddr_in == `CRS_OFS_ISP) begin
			isp_q <= pwdata_in[15:0];
		end
	end

	// later assignments win: hardware events override software writes
	always_comb begin
		flag_d = flag_q;
		if (wr_in.en && wr_in.idx == `CRS_IDX_FLG) begin
			flag_d = wr_in.data[15:0] & `CRS_FLG_WMASK;
		end else if (apb_wr && paddr_in == `CRS_OFS_FLAGS) begin
			flag_d = pwdata_in[15:0] & `CRS_FLG_WMASK;
		end
		if (alu_in.valid) begin
			flag_d[`CRS_FLG_C] = alu_in.carry;
			flag_d[`CRS_FLG_Z] = (alu_in.result == 16'h0000);
			flag_d[`CRS_FLG_S] = alu_in.result[15];
			flag_d[`CRS_FLG_O] = alu_in.ovf;
		end
		if (ack_in.accept) begin
			flag_d[`CRS_FLG_I] = 1'b0;
			flag_d[`CRS_FLG_U] = 1'b0;
			if (ack_in.step) begin
				flag_d[`CRS_FLG_D] = 1'b0;
			end
		end
		if (ack_in.trap && ack_in.trap_num < `CRS_SWTRAP_LIMIT) begin
			flag_d[`CRS_FLG_U] = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			flag_q <= `CRS_FLG_RESET;
		end else if (clr) begin
			flag_q <= `CRS_FLG_RESET;
		end else begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pc_q <= 20'h00000;
		end else if (clr) begin
			pc_q <= 20'h00000;
		end else if (state_q == CRS_ST_VECTOR) begin
			if (vec_valid_in) begin
				pc_q <= vec_data_in;
			end
		end else if (pc_load_in) begin
			pc_q <= pc_next_in;
		end else if (apb_wr && paddr_in == `CRS_OFS_PC) begin
			pc_q <= pwdata_in[19:0];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			vector_table_base_q <= 20'h00000;
		end else if (clr) begin
			vector_table_base_q <= 20'h00000;
		end else if (vector_table_base_load_in) begin
			vector_table_base_q <= vector_table_base_next_in;
		end else if (apb_wr && paddr_in == `CRS_OFS_VECTOR_TABLE_BASE) begin
			vector_table_base_q <= pwdata_in[19:0];
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (rd_idx_in < `CRS_IDX_SB) begin
			rd_mux = {16'h0000, bank_q[bank][rd_idx_in[2:0]]};
			if (rd_size_in == CRS_SZ_HIGH && rd_idx_in < 4'd2) begin
				rd_mux = {24'h000000, bank_q[bank][rd_idx_in[2:0]][15:8]};
			end else if (rd_size_in == CRS_SZ_LOW && rd_idx_in < 4'd2) begin
				rd_mux = {24'h000000, bank_q[bank][rd_idx_in[2:0]][7:0]};
			end else if (rd_size_in == CRS_SZ_LONG && rd_idx_in < 4'd2) begin
				rd_mux = {bank_q[bank][rd_idx_in[2:0] + 3'd2],
					bank_q[bank][rd_idx_in[2:0]]};
			end else if (rd_size_in == CRS_SZ_LONG && rd_idx_in == 4'd4) begin
				rd_mux = {bank_q[bank][5], bank_q[bank][4]};
			end
		end else if (rd_idx_in == `CRS_IDX_SB) begin
			rd_mux = {16'h0000, sb_q};
		end else if (rd_idx_in == `CRS_IDX_SP) begin
			rd_mux = {16'h0000, flag_q[`CRS_FLG_U] ? usp_q : isp_q};
		end else if (rd_idx_in == `CRS_IDX_USP) begin
			rd_mux = {16'h0000, usp_q};
		end else if (rd_idx_in == `CRS_IDX_ISP) begin
			rd_mux = {16'h0000, isp_q};
		end else if (rd_idx_in == `CRS_IDX_FLG) begin
			rd_mux = {16'h0000, flag_q};
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 32'h00000000;
		end else begin
			rd_data_out <= rd_mux;
		end
	end

	// the grant is computed against the flag word of this cycle
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			irq_grant_out <= 1'b0;
		end else begin
			irq_grant_out <= cpu_run_out && irq_in.req && (irq_in.nmi ||
				(flag_q[`CRS_FLG_I] &&
				irq_in.prio > flag_q[`CRS_FLG_IPL_HI:`CRS_FLG_IPL_LO]));
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			step_req_out <= 1'b0;
		end else if (instr_done_in && flag_q[`CRS_FLG_D]) begin
			step_req_out <= 1'b1;
		end else if (ack_in.accept && ack_in.step) begin
			step_req_out <= 1'b0;
		end
	end

	// out-of-range vector numbers fold onto the last entry of the area
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			fixvec_addr_out <= `CRS_FIXVEC_BASE;
			spvec_addr_out <= `CRS_SPVEC_BASE;
		end else begin
			if (state_q != CRS_ST_RUN) begin
				fixvec_addr_out <= `CRS_FIXVEC_BASE + {14'h0000, `CRS_FIXVEC_RESET, 2'h0};
			end else if (fixvec_num_in < `CRS_FIXVEC_CNT) begin
				fixvec_addr_out <= `CRS_FIXVEC_BASE + {14'h0000, fixvec_num_in, 2'h0};
			end else begin
				fixvec_addr_out <= `CRS_FIXVEC_BASE + {14'h0000, `CRS_FIXVEC_RESET, 2'h0};
			end
			if (spvec_num_in < `CRS_SPVEC_CNT) begin
				spvec_addr_out <= `CRS_SPVEC_BASE + {11'h000, spvec_num_in, 1'b0};
			end else begin
				spvec_addr_out <= `CRS_SPVEC_BASE + {11'h000, `CRS_SPVEC_CNT - 8'd1, 1'b0};
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			map_region_out <= CRS_RGN_SFR;
		end else if (map_addr_in <= `CRS_SFR_LAST) begin
			map_region_out <= CRS_RGN_SFR;
		end else if (map_addr_in >= `CRS_RAM_BASE && map_addr_in < `CRS_SPVEC_BASE) begin
			map_region_out <= CRS_RGN_RAM;
		end else begin
			map_region_out <= CRS_RGN_OTHER;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			flags_out <= `CRS_FLG_RESET;
			pc_out <= 20'h00000;
			vector_table_base_out <= 20'h00000;
		end else begin
			flags_out <= flag_q;
			pc_out <= pc_q;
			vector_table_base_out <= vector_table_base_q;
		end
	end

	// one access cycle; read data is latched in the setup cycle
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
		end else begin
			pready_out <= apb_setup;
			pslverr_out <= 1'b0;
			if (apb_setup) begin
				prdata_out <= 32'h00000000;
				unique case (paddr_in)
					`CRS_OFS_MODE0: prdata_out <= 32'h00000000;
					`CRS_OFS_FLAGS: prdata_out <= {16'h0000, flag_q};
					`CRS_OFS_PC: prdata_out <= {12'h000, pc_q};
					`CRS_OFS_VECTOR_TABLE_BASE: prdata_out <= {12'h000, vector_table_base_q};
					`CRS_OFS_SB: prdata_out <= {16'h0000, sb_q};
					`CRS_OFS_USP: prdata_out <= {16'h0000, usp_q};
					`CRS_OFS_ISP: prdata_out <= {16'h0000, isp_q};
					`CRS_OFS_STATUS: prdata_out <= {28'h0000000, last_sw_q, state_q};
					default: pslverr_out <= 1'b1;
				endcase
			end
		end
	end
endmodule

//--- crs_regfile_checker.sv
// Purpose: concurrent checks on the cpu register file ports
// Assumes: one clock domain, rst_in asynchronous and active high
// Notes: flags_out and pc_out lag the registers by one edge
`timescale 1ns/1ns
module crs_regfile_checker (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic reset_pin_n_in,
	// apb
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [11:0] paddr_in,
	// core side
	input wire crs_pkg::crs_alu_s alu_in,
	input wire crs_pkg::crs_irq_s irq_in,
	input wire logic irq_grant_out,
	input wire logic [3:0] fixvec_num_in,
	input wire crs_pkg::crs_addr_t fixvec_addr_out,
	input wire logic [7:0] spvec_num_in,
	input wire crs_pkg::crs_addr_t spvec_addr_out,
	input wire crs_pkg::crs_addr_t map_addr_in,
	input wire crs_pkg::crs_region_e map_region_out,
	// reset entry and state
	input wire logic vec_fetch_out,
	input wire logic vec_valid_in,
	input wire crs_pkg::crs_addr_t vec_data_in,
	input wire logic cpu_run_out,
	input wire crs_pkg::crs_word_t flags_out,
	input wire crs_pkg::crs_addr_t pc_out
);
	import crs_pkg::*;
	logic [7:0] low_q;
	crs_alu_s alu_q, alu_qq;
	crs_irq_s irq_q;
	wire mapped = paddr_in inside {12'h004, 12'h100, 12'h104, 12'h108, 12'h10C, 12'h110,
		12'h114, 12'h118};
	// flags_out shows the flag word one edge late, so the cause is delayed to match
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			alu_q <= '0;
			alu_qq <= '0;
			irq_q <= '0;
			low_q <= 8'h00;
		end else begin
			alu_q <= alu_in;
			alu_qq <= alu_q;
			irq_q <= irq_in;
			low_q <= reset_pin_n_in ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
		end
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	a_slverr_map: assert property (pready_out |-> pslverr_out == !mapped)
		else $error("slave error does not match the address map");
	a_flag_reserved: assert property (flags_out[11:8] == 4'h0 && !flags_out[15])
		else $error("reserved flag bits not zero");
	a_grant_level: assert property (irq_grant_out |-> irq_q.req &&
		(irq_q.nmi || (flags_out[6] && irq_q.prio > flags_out[14:12])))
		else $error("interrupt granted against enable or level");
	a_alu_flags: assert property (alu_qq.valid |->
		{flags_out[5], flags_out[3:2], flags_out[0]} == {alu_qq.ovf, alu_qq.result[15],
		alu_qq.result == 16'h0000, alu_qq.carry})
		else $error("arithmetic flags do not follow the result");
	a_spvec_addr: assert property (spvec_addr_out == 20'hFFE00 +
		{11'h000, ($past(spvec_num_in) > 8'hED ? 8'hED : $past(spvec_num_in)), 1'h0})
		else $error("special page vector address wrong");
	a_fixvec_addr: assert property (fixvec_addr_out == 20'hFFFFC ||
		fixvec_addr_out == 20'hFFFDC + {14'h0000, $past(fixvec_num_in), 2'h0})
		else $error("fixed vector address wrong");
	a_map_region: assert property (map_region_out == ($past(map_addr_in) <= 20'h003FF ?
		CRS_RGN_SFR : ($past(map_addr_in) <= 20'hFFDFF ? CRS_RGN_RAM : CRS_RGN_OTHER)))
		else $error("address region wrong");
	a_vec_entry: assert property (vec_fetch_out && vec_valid_in |=>
		cpu_run_out && !vec_fetch_out ##1 pc_out == $past(vec_data_in, 2))
		else $error("reset vector not taken into the program counter");
	a_pin_reset: assert property (low_q == 8'h1C |-> !cpu_run_out && !vec_fetch_out)
		else $error("long reset pin low did not stop the cpu");
endmodule

//--- crs_reset_src.sv
// Purpose: external reset source driving the active-low reset pin
// Assumes: lengths counted in clk_sys_in cycles
// Notes: lows shorter than the minimum only come when the bench asks
`timescale 1ns/1ns
module crs_reset_src (
	// clock
	input wire logic clk_sys_in,
	// command
	input wire logic go_in,
	input wire logic [7:0] low_cycles_in,
	// reset pin
	output logic pin_n_out
);
	// power-on low of 24 cycles keeps above the 20-cycle minimum
	logic [7:0] left_q = 8'h18;
	always @(posedge clk_sys_in) begin
		if (go_in)
			left_q <= low_cycles_in;
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end
	assign pin_n_out = (left_q == 8'h00);
endmodule

//--- crs_tb_top.sv
// Purpose: self-checking bench for the cpu register file
// Assumes: apb answers in the access cycle
// Notes: reads are noted in queues and compared by monitors
`timescale 1ns/1ns
module cpu_register_set_and_reset_entry_tb_top;
	import crs_pkg::*;
	logic clk_sys_in = 1'h0, rst_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
	logic rd_look = 1'h0, instr_done_in = 1'h0, vec_valid_in = 1'h0, quiet = 1'h1, go = 1'h0;
	logic reset_pin_n_in, pready_out, pslverr_out, irq_grant_out, step_req_out, vec_fetch_out;
	logic cpu_run_out;
	logic pc_load_in = 1'h0, vector_table_base_load_in = 1'h0;
	crs_addr_t pc_next_in = '0, vector_table_base_next_in = '0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = '0, mix_q = 32'h2E, r, prdata_out, rd_data_out;
	logic [7:0] low_len = 8'h00, spvec_num_in = 8'h00;
	logic [3:0] rd_idx_in = 4'h0, fixvec_num_in = 4'h0;
	crs_size_e rd_size_in = CRS_SZ_WORD;
	crs_wr_s wr_in = '0;
	crs_alu_s alu_in = '0;
	crs_irq_s irq_in = '0;
	crs_ack_s ack_in = '0;
	crs_addr_t map_addr_in = '0, vec_data_in = '0, fixvec_addr_out, spvec_addr_out, pc_out, vector_table_base_out;
	crs_region_e map_region_out;
	crs_word_t flags_out;
	logic [32:0] aq[$];
	logic [31:0] rq[$];
	int failures = 0, check_count = 0;
	logic [11:0] ofs [5] = '{12'h100, 12'h108, 12'h10C, 12'h110, 12'h114};
	logic [31:0] msk [5] = '{32'h70FF, 32'hFFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF};
	logic [3:0] idx [3] = '{4'h0, 4'h1, 4'h4};
	crs_alu_s alu_tab [3] = '{'{1'h1, 1'h1, 1'h0, 16'h0000}, '{1'h1, 1'h0, 1'h1, 16'h8001},
		'{1'h1, 1'h1, 1'h1, 16'h7FFF}};
	crs_ack_s ack_tab [4] = '{'{1'h1, 1'h0, 1'h0, 6'h00}, '{1'h0, 1'h0, 1'h1, 6'h05},
		'{1'h0, 1'h0, 1'h1, 6'h1F}, '{1'h0, 1'h0, 1'h1, 6'h20}};
	logic [15:0] ack_exp [4] = '{16'h3000, 16'h3040, 16'h3040, 16'h30C0};
	crs_reset_src src (.clk_sys_in, .go_in(go), .low_cycles_in(low_len), .pin_n_out(reset_pin_n_in));
	crs_regfile uut (.clk_sys_in, .rst_in, .reset_pin_n_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .wr_in, .rd_idx_in,
		.rd_size_in, .rd_data_out, .alu_in, .pc_load_in, .pc_next_in,
		.vector_table_base_load_in, .vector_table_base_next_in, .irq_in, .ack_in, .instr_done_in,
		.irq_grant_out, .step_req_out, .fixvec_num_in, .spvec_num_in, .fixvec_addr_out,
		.spvec_addr_out, .map_addr_in, .map_region_out, .vec_fetch_out, .vec_valid_in,
		.vec_data_in, .cpu_run_out, .flags_out, .pc_out, .vector_table_base_out);
	always #20 clk_sys_in = ~clk_sys_in;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// lookups are held at zero around resets so the registered outputs agree either way
	always @(posedge clk_sys_in) begin
		mix_q <= xs(mix_q);
		fixvec_num_in <= quiet ? 4'h0 : mix_q[3:0];
		spvec_num_in <= quiet ? 8'h00 : mix_q[11:4];
		map_addr_in <= quiet ? 20'h00000 : {mix_q[12] ? 8'h00 : mix_q[31:24], mix_q[23:12]};
	end
	task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t exp=%h got=%h", $time, e, g);
		end
	endtask
	always @(posedge clk_sys_in)
		if (psel_in && penable_in && !pwrite_in && pready_out === 1'h1)
			cmp_apb(aq.pop_front(), {pslverr_out, prdata_out});
	always @(negedge clk_sys_in)
		if (rd_look)
			cmp_rd(rq.pop_front(), rd_data_out);
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		if (!w)
			aq.push_back(e);
		psel_in <= 1'h1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'h1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk_sys_in);
			if (pready_out === 1'h1)
				break;
		end
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		@(posedge clk_sys_in);
	endtask
	task automatic core_wr(input logic [3:0] i, input crs_size_e s, input logic [31:0] d);
		wr_in <= '{1'h1, i, s, d};
		@(posedge clk_sys_in);
		wr_in.en <= 1'h0;
		@(posedge clk_sys_in);
	endtask
	task automatic core_rd(input logic [3:0] i, input crs_size_e s, input logic [31:0] e);
		rq.push_back(e);
		rd_idx_in <= i;
		rd_size_in <= s;
		@(posedge clk_sys_in);
		rd_look <= 1'h1;
		@(posedge clk_sys_in);
		rd_look <= 1'h0;
	endtask
	task automatic pulse_ack(input crs_ack_s a);
		ack_in <= a;
		@(posedge clk_sys_in);
		ack_in <= '0;
		@(posedge clk_sys_in);
	endtask
	task automatic vector(input crs_addr_t v);
		for (int n = 0; n < 300 && vec_fetch_out !== 1'h1; n++)
			@(posedge clk_sys_in);
		vec_valid_in <= 1'h1;
		vec_data_in <= v;
		@(posedge clk_sys_in);
		vec_valid_in <= 1'h0;
		vec_data_in <= ~v;
		repeat (3) @(posedge clk_sys_in);
		apb(1'h0, 12'h104, '0, {13'h0, v});
	endtask
	task automatic close_out();
		if (failures == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		failures++;
		close_out();
	end
	initial begin
		repeat (5) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		vector(mix_q[19:0]);
		quiet <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			apb(1'h0, ofs[i], '0, '0);
			r = mix_q;
			apb(1'h1, ofs[i], r, '0);
			apb(1'h0, ofs[i], '0, {1'h0, r & msk[i]});
		end
		pc_load_in <= 1'h1;
		vector_table_base_load_in <= 1'h1;
		pc_next_in <= 20'h13579;
		vector_table_base_next_in <= 20'hABCDE;
		@(posedge clk_sys_in);
		pc_load_in <= 1'h0;
		vector_table_base_load_in <= 1'h0;
		repeat (2) @(posedge clk_sys_in);
		cmp_rd(32'h13579, {12'h0, pc_out});
		cmp_rd(32'hABCDE, {12'h0, vector_table_base_out});
		apb(1'h0, 12'h0FC, '0, {1'h1, 32'h0});
		apb(1'h0, 12'h004, '0, '0);
		for (int b = 0; b < 4; b++) begin
			apb(1'h1, 12'h100, {27'h0, b[0], 4'h0}, '0);
			for (int j = 0; j < 3; j++)
				if (b < 2)
					core_wr(idx[j], CRS_SZ_LONG, 32'h11111111 * (b * 3 + j + 1));
				else
					core_rd(idx[j], CRS_SZ_LONG, 32'h11111111 * (b * 3 + j - 5));
		end
		apb(1'h1, 12'h100, '0, '0);
		core_wr(4'h1, CRS_SZ_HIGH, 32'h0000A5A5);
		core_wr(4'h1, CRS_SZ_LOW, 32'h00005A5A);
		core_rd(4'h1, CRS_SZ_LONG, 32'h2222A55A);
		core_wr(4'h8, CRS_SZ_WORD, 32'h00001357);
		apb(1'h0, 12'h114, '0, 33'h1357);
		apb(1'h1, 12'h100, 32'h80, '0);
		core_wr(4'h8, CRS_SZ_WORD, 32'h00002468);
		apb(1'h0, 12'h110, '0, 33'h2468);
		for (int k = 0; k < 3; k++) begin
			apb(1'h1, 12'h100, '0, '0);
			alu_in <= alu_tab[k];
			@(posedge clk_sys_in);
			alu_in.valid <= 1'h0;
			@(posedge clk_sys_in);
			apb(1'h0, 12'h100, '0, {27'h0, alu_tab[k].ovf, 1'h0, alu_tab[k].result[15],
				alu_tab[k].result == 16'h0000, 1'h0, alu_tab[k].carry});
		end
		apb(1'h1, 12'h100, 32'h30C0, '0);
		irq_in <= '{1'h1, 1'h0, 3'h4};
		repeat (3) @(posedge clk_sys_in);
		cmp_rd(32'h1, {31'h0, irq_grant_out});
		irq_in.prio <= 3'h3;
		repeat (3) @(posedge clk_sys_in);
		cmp_rd(32'h0, {31'h0, irq_grant_out});
		irq_in <= '0;
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, 12'h100, 32'h30C0, '0);
			pulse_ack(ack_tab[k]);
			apb(1'h0, 12'h100, '0, {17'h0, ack_exp[k]});
		end
		apb(1'h1, 12'h100, 32'h2, '0);
		instr_done_in <= 1'h1;
		@(posedge clk_sys_in);
		instr_done_in <= 1'h0;
		repeat (2) @(posedge clk_sys_in);
		cmp_rd(32'h1, {31'h0, step_req_out});
		pulse_ack('{1'h1, 1'h1, 1'h0, 6'h00});
		apb(1'h0, 12'h100, '0, '0);
		cmp_rd(32'h0, {31'h0, step_req_out});
		quiet <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		apb(1'h1, 12'h004, 32'h8, '0);
		vector(20'h0ABCD);
		apb(1'h0, 12'h118, '0, 33'hC);
		apb(1'h0, 12'h100, '0, '0);
		low_len <= 8'h0A;
		go <= 1'h1;
		@(posedge clk_sys_in);
		go <= 1'h0;
		repeat (20) @(posedge clk_sys_in);
		cmp_rd(32'h1, {31'h0, cpu_run_out});
		low_len <= 8'h20;
		go <= 1'h1;
		@(posedge clk_sys_in);
		go <= 1'h0;
		vector(20'h54321);
		apb(1'h0, 12'h118, '0, 33'h4);
		close_out();
	end
endmodule
bind crs_regfile crs_regfile_checker chk (.clk_sys_in, .rst_in, .reset_pin_n_in, .pready_out,
	.pslverr_out, .paddr_in, .alu_in, .irq_in, .irq_grant_out, .fixvec_num_in, .fixvec_addr_out,
	.spvec_num_in, .spvec_addr_out,
	.map_addr_in, .map_region_out, .vec_fetch_out, .vec_valid_in, .vec_data_in, .cpu_run_out,
	.flags_out, .pc_out);
